// ==== logic/fdoc_decode.sv ====
module fdoc_decode (
  // register contents
  input  wire logic [7:0]                doc,
  input  wire fdoc_pkg::fdoc_decode_t    mode,
  // decoded active-low drive pins
  output fdoc_pkg::fdoc_drive_pins_t     pins
);

  logic [1:0] num;
  logic [3:0] motor;
  logic [3:0] sel;

  always_comb
  begin
    num   = doc[fdoc_pkg::DRV_NUM_MSB:fdoc_pkg::DRV_NUM_LSB];
    motor = doc[fdoc_pkg::MOTOR_MSB:fdoc_pkg::MOTOR_LSB];
    sel   = 4'h0;
    pins  = '{select_low: 4'hf, spindle_low: 4'hf};
    unique case (mode)
      fdoc_pkg::FDOC_DEC_SWAPPED:
      begin
        // drives 0 and 1 exchange their lines
        sel[{num[1], num[0] ^ ~num[1]}] = motor[num];
        pins.select_low  = ~sel;
        pins.spindle_low = ~{motor[3], motor[2], motor[0], motor[1]};
      end
      fdoc_pkg::FDOC_DEC_EXTERNAL:
      begin
        // binary number out, one shared motor line
        pins.select_low  = {2'b11, num};
        pins.spindle_low = {3'b111, ~motor[num]};
      end
      default:
      begin
        // normal; an unused mode code falls back here
        sel[num]         = motor[num];
        pins.select_low  = ~sel;
        pins.spindle_low = ~motor;
      end
    endcase
  end

endmodule

// ==== logic/fdoc_pkg.sv ====
package fdoc_pkg;

  // host port addresses
  localparam logic [9:0] ADDR_DRIVE_OUTPUT_CONTROL = 10'h03f2;
  localparam logic [9:0] ADDR_TAPE_DRIVE_SELECT    = 10'h03f3;

  // drive output control field positions
  localparam int unsigned DRV_NUM_LSB   = 0;
  localparam int unsigned DRV_NUM_MSB   = 1;
  localparam int unsigned SOFT_RST_BIT  = 2;
  localparam int unsigned DMA_GATE_BIT  = 3;
  localparam int unsigned MOTOR_LSB     = 4;
  localparam int unsigned MOTOR_MSB     = 7;

  // reset values
  localparam logic [7:0] DOC_RESET  = 8'h00;
  localparam logic [1:0] TAPE_RESET = 2'h0;

  // software reset timing
  localparam int unsigned SOFT_RST_MIN_NS = 100;
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned SOFT_RST_MIN_CYC =
    (SOFT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FDOC_DEC_NORMAL   = 2'b00,
    FDOC_DEC_SWAPPED  = 2'b01,
    FDOC_DEC_EXTERNAL = 2'b10
  } fdoc_decode_t;

  typedef enum logic [1:0] {
    FDOC_SYS_LEGACY_AT = 2'b00,
    FDOC_SYS_LEGACY_30 = 2'b01,
    FDOC_SYS_ALTERNATE = 2'b10
  } fdoc_sysmode_t;

  // host write/read request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } fdoc_host_req_t;

  // drive pins, all active low
  typedef struct packed {
    logic [3:0] select_low;
    logic [3:0] spindle_low;
  } fdoc_drive_pins_t;

endpackage

// ==== logic/fdoc_top.sv ====
// Function
// - hardware reset clears the output control register; software reset leaves it; writes always.
// - bits 1:0 are a binary drive number; at most one drive selected.
// - writing 0 to bit 2 holds the controller in reset until 1 written.
// - software reset leaves rate, config and other control bits unchanged.
// - software reset lasts at least 100 ns; back-to-back low/high writes work.
// - in legacy modes bit 3 enables dma request/ack, terminal count and irq.
// - legacy, gate clear: ignore ack and count, float request and irq.
// - legacy: gate bit reads zero after hardware reset; software reset leaves it.
// - alternate mode: dma and irq pins always enabled; gate still cleared.
// - bits 7:4 drive motor outputs 3:0, active low, in normal decode; swapped and external decode remap them.
// - tape register stored, unused internally, kept over software reset.
// - tape register read in normal mode drives only bits 1:0.
// - tape bits encode none, drive 1, 2 or 3; stored only.
// - normal decode selects numbered drive only with its motor bit set.
// - swapped decode exchanges drives 0 and 1, selects and motors.
// - external decode outputs binary number and one shared motor line.
module fdoc_top (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  // host i/o port
  input  wire fdoc_pkg::fdoc_host_req_t  host_req,
  output logic [7:0]                     host_rdata,
  output logic [7:0]                     host_rdata_oe_n,
  // configuration
  input  wire fdoc_pkg::fdoc_decode_t    decode_mode,
  input  wire fdoc_pkg::fdoc_sysmode_t   sys_mode,
  // controller-core side dma, interrupt and soft reset
  input  wire logic                      core_dma_req,
  input  wire logic                      core_irq,
  output logic                           core_dma_ack,
  output logic                           core_term_count,
  output logic                           core_soft_reset,
  // dma and interrupt pins
  input  wire logic                      dma_ack_low,
  input  wire logic                      term_count,
  output logic                           dma_req_out,
  output logic                           dma_req_oe_n,
  output logic                           floppy_irq_line,
  output logic                           floppy_irq_oe_n,
  // drive pins
  output fdoc_pkg::fdoc_drive_pins_t     drive_pins
);

  // hold counter wide enough for the minimum soft reset length
  localparam int unsigned HOLD_W = $clog2(fdoc_pkg::SOFT_RST_MIN_CYC);

  logic [7:0]                  drive_output_control;
  logic [7:0]                  next_drive_output_control;
  logic [1:0]                  tape_choice_bit;
  logic [1:0]                  next_tape_choice_bit;
  logic [7:0]                  next_host_rdata;
  logic [7:0]                  next_host_rdata_oe_n;
  fdoc_pkg::fdoc_drive_pins_t  dec_pins;
  logic                        gate_open;
  logic                        soft_reset_low;
  logic                        next_core_dma_ack;
  logic                        next_core_term_count;
  logic                        next_dma_req_out;
  logic                        next_dma_req_oe_n;
  logic                        next_irq;
  logic                        next_irq_oe_n;
  logic                        next_core_soft_reset;
  logic [HOLD_W-1:0]           soft_rst_hold;
  logic [HOLD_W-1:0]           next_soft_rst_hold;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] target);
    hit = (a == target);
  endfunction

  // register writes
  always_comb
  begin
    next_drive_output_control = drive_output_control;
    next_tape_choice_bit      = tape_choice_bit;
    if (host_req.wr && hit(host_req.addr, fdoc_pkg::ADDR_DRIVE_OUTPUT_CONTROL))
    begin
      next_drive_output_control = host_req.wdata;
    end
    if (host_req.wr && hit(host_req.addr, fdoc_pkg::ADDR_TAPE_DRIVE_SELECT))
    begin
      next_tape_choice_bit = host_req.wdata[1:0];
    end
  end

  // only hardware reset touches these; the soft reset bit never feeds back here
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      drive_output_control <= fdoc_pkg::DOC_RESET;
      tape_choice_bit      <= fdoc_pkg::TAPE_RESET;
    end
    else
    begin
      drive_output_control <= next_drive_output_control;
      tape_choice_bit      <= next_tape_choice_bit;
    end
  end

  // reads: tape register floats bits 7:2; unmapped addresses float all
  always_comb
  begin
    next_host_rdata      = 8'h00;
    next_host_rdata_oe_n = 8'hff;
    if (host_req.rd && hit(host_req.addr, fdoc_pkg::ADDR_DRIVE_OUTPUT_CONTROL))
    begin
      next_host_rdata      = drive_output_control;
      next_host_rdata_oe_n = 8'h00;
    end
    else if (host_req.rd && hit(host_req.addr, fdoc_pkg::ADDR_TAPE_DRIVE_SELECT))
    begin
      next_host_rdata      = {6'h00, tape_choice_bit};
      next_host_rdata_oe_n = 8'hfc;
    end
  end

  fdoc_decode u_decode (
    .doc  (drive_output_control),
    .mode (decode_mode),
    .pins (dec_pins)
  );

  // dma and interrupt gating
  always_comb
  begin
    soft_reset_low       = drive_output_control[fdoc_pkg::SOFT_RST_BIT];
    gate_open            = (sys_mode == fdoc_pkg::FDOC_SYS_ALTERNATE)
                         || drive_output_control[fdoc_pkg::DMA_GATE_BIT];
    next_core_dma_ack    = gate_open && !dma_ack_low;
    next_core_term_count = gate_open && term_count;
    next_dma_req_out     = gate_open && core_dma_req;
    next_dma_req_oe_n    = !gate_open;
    next_irq             = gate_open && core_irq;
    next_irq_oe_n        = !gate_open;
  end

  // stretch: a low/high write pair one cycle apart is still a full-length reset
  always_comb
  begin
    next_soft_rst_hold = soft_rst_hold;
    if (!soft_reset_low)
    begin
      next_soft_rst_hold = HOLD_W'(fdoc_pkg::SOFT_RST_MIN_CYC - 1);
    end
    else if (soft_rst_hold != '0)
    begin
      next_soft_rst_hold = soft_rst_hold - HOLD_W'(1);
    end
    next_core_soft_reset = !soft_reset_low || (soft_rst_hold != '0);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      host_rdata      <= 8'h00;
      host_rdata_oe_n <= 8'hff;
      drive_pins      <= '{select_low: 4'hf, spindle_low: 4'hf};
      core_soft_reset <= 1'b1;
      core_dma_ack    <= 1'b0;
      core_term_count <= 1'b0;
      dma_req_out     <= 1'b0;
      // legacy modes float the pins through reset; alternate mode keeps them driven
      dma_req_oe_n    <= (sys_mode != fdoc_pkg::FDOC_SYS_ALTERNATE);
      floppy_irq_line <= 1'b0;
      floppy_irq_oe_n <= (sys_mode != fdoc_pkg::FDOC_SYS_ALTERNATE);
      soft_rst_hold   <= '0;
    end
    else
    begin
      host_rdata      <= next_host_rdata;
      host_rdata_oe_n <= next_host_rdata_oe_n;
      drive_pins      <= dec_pins;
      core_soft_reset <= next_core_soft_reset;
      soft_rst_hold   <= next_soft_rst_hold;
      core_dma_ack    <= next_core_dma_ack;
      core_term_count <= next_core_term_count;
      dma_req_out     <= next_dma_req_out;
      dma_req_oe_n    <= next_dma_req_oe_n;
      floppy_irq_line <= next_irq;
      floppy_irq_oe_n <= next_irq_oe_n;
    end
  end

endmodule

// ==== verification/fdoc_checker.sv ====
module fdoc_checker (
  // clock and reset
  input wire logic                       mclk,
  input wire logic                       rst_n,
  // watched ports
  input wire fdoc_pkg::fdoc_host_req_t   host_req,
  input wire logic [7:0]                 host_rdata_oe_n,
  input wire fdoc_pkg::fdoc_decode_t     decode_mode,
  input wire fdoc_pkg::fdoc_sysmode_t    sys_mode,
  input wire logic                       core_dma_ack,
  input wire logic                       core_soft_reset,
  input wire logic                       dma_req_oe_n,
  input wire fdoc_pkg::fdoc_drive_pins_t drive_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // control write; pins follow two edges later
  sequence s_wr;
    host_req.wr && host_req.addr == fdoc_pkg::ADDR_DRIVE_OUTPUT_CONTROL;
  endsequence
  sequence s_wr_in(m);
    s_wr ##0 decode_mode == m;
  endsequence
  a_soft_rst_on: assert property (s_wr ##0 !host_req.wdata[2] |-> ##2 core_soft_reset)
    else $error("soft reset");
  a_motor_norm: assert property (s_wr_in(fdoc_pkg::FDOC_DEC_NORMAL)
    |-> ##2 drive_pins.spindle_low == ~$past(host_req.wdata[7:4], 2)) else $error("motor");
  a_motor_swap: assert property (s_wr_in(fdoc_pkg::FDOC_DEC_SWAPPED) |-> ##2
    drive_pins.spindle_low[1:0] == ~{$past(host_req.wdata[4], 2), $past(host_req.wdata[5], 2)})
    else $error("swap");
  a_one_select: assert property (decode_mode != fdoc_pkg::FDOC_DEC_EXTERNAL &&
    $past(decode_mode) != fdoc_pkg::FDOC_DEC_EXTERNAL |-> $onehot0(~drive_pins.select_low))
    else $error("select");
  a_gate_shut: assert property (s_wr ##0 !host_req.wdata[3] &&
    sys_mode != fdoc_pkg::FDOC_SYS_ALTERNATE |-> ##2 dma_req_oe_n) else $error("gate");
  a_alt_open: assert property (sys_mode == fdoc_pkg::FDOC_SYS_ALTERNATE |=> !dma_req_oe_n)
    else $error("alt");
  a_ack_block: assert property (dma_req_oe_n |-> !core_dma_ack) else $error("ack");
  a_tape_read: assert property (host_req.rd &&
    host_req.addr == fdoc_pkg::ADDR_TAPE_DRIVE_SELECT |=> host_rdata_oe_n == 8'hfc)
    else $error("tape");
endmodule
bind fdoc_top fdoc_checker u_chk (.mclk, .rst_n, .host_req, .host_rdata_oe_n, .decode_mode,
  .sys_mode, .core_dma_ack, .core_soft_reset, .dma_req_oe_n, .drive_pins);

// ==== verification/fdoc_drive_model.sv ====
module fdoc_drive_model (
  // drive cable
  input  wire fdoc_pkg::fdoc_drive_pins_t pins,
  // selected drive, 4 when none
  output logic [2:0]                      sel_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  // each drive answers only its own select line
  always_comb
  begin
    sel_drive = 3'h4;
    for (int i = 0; i < 4; i++)
      if (!pins.select_low[i])
        sel_drive = 3'(i);
  end
endmodule

// ==== verification/fdoc_top_tb.sv ====
module fdoc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] DOC = fdoc_pkg::ADDR_DRIVE_OUTPUT_CONTROL;
  logic                       mclk, rst_n, dma_ack_low, term_count, dma_req_oe_n;
  logic                       dma_req_out, floppy_irq_line, floppy_irq_oe_n, core_req;
  logic [5:0]                 gate_view;
  logic                       core_dma_ack, core_term_count, core_soft_reset;
  logic [7:0]                 rd_data, rd_oe_n;
  logic [2:0]                 sel_drive;
  fdoc_pkg::fdoc_host_req_t   host_req;
  fdoc_pkg::fdoc_decode_t     decode_mode;
  fdoc_pkg::fdoc_sysmode_t    sys_mode;
  fdoc_pkg::fdoc_drive_pins_t pins;
  int                         checks, n_mismatch, cnt;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
  fdoc_top uut (.mclk, .rst_n, .host_req, .host_rdata(rd_data), .host_rdata_oe_n(rd_oe_n),
    .decode_mode, .sys_mode, .core_dma_req(core_req), .core_irq(core_req), .core_dma_ack,
    .core_term_count, .core_soft_reset, .dma_ack_low, .term_count, .dma_req_out,
    .dma_req_oe_n, .floppy_irq_line, .floppy_irq_oe_n, .drive_pins(pins));
  fdoc_drive_model u_drv (.pins, .sel_drive);
  assign gate_view = {dma_req_oe_n, floppy_irq_oe_n, dma_req_out, floppy_irq_line,
                      core_dma_ack, core_term_count};
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    host_req <= '{w, !w, a, d};
    @(posedge mclk);
    host_req <= '0;
    @(negedge mclk);
  endtask
  task automatic settle;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    {rst_n, dma_ack_low, term_count, host_req, checks, n_mismatch} = '0;
    term_count = 1'h1;
    core_req = 1'h1;
    decode_mode = fdoc_pkg::FDOC_DEC_NORMAL;
    sys_mode = fdoc_pkg::FDOC_SYS_LEGACY_AT;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    `CHK("rst_float", 2'h3, {dma_req_oe_n, floppy_irq_oe_n})
    @(posedge mclk);
    rst_n <= 1'h1;
    acc(0, DOC, 8'h00);
    `CHK("doc", 8'h00, rd_data)
    `CHK("pins", 8'hff, pins)
    `CHK("ack", 2'h0, {core_dma_ack, core_term_count})
    for (int n = 0; n < 4; n++)
    begin
      acc(1, DOC, 8'h0c | (8'h10 << n) | 8'(n));
      settle;
      `CHK("sel", ~(4'h1 << n), pins.select_low)
      `CHK("mtr", ~(4'h1 << n), pins.spindle_low)
      `CHK("drv", 3'(n), sel_drive)
      `CHK("on", 6'h0f, gate_view)
    end
    for (cnt = 0; core_soft_reset === 1'h1 && cnt < 20; cnt++)
      settle;
    `CHK("srst", 1'h0, core_soft_reset)
    for (int t = 0; t < 4; t++)
    begin
      acc(1, fdoc_pkg::ADDR_TAPE_DRIVE_SELECT, 8'hfc | 8'(t));
      acc(0, fdoc_pkg::ADDR_TAPE_DRIVE_SELECT, 8'h00);
      `CHK("tape", {8'hfc, 2'(t)}, {rd_oe_n, rd_data[1:0]})
    end
    acc(1, DOC, 8'h8b);
    acc(1, DOC, 8'h8f);
    for (cnt = 0; core_soft_reset === 1'h1 && cnt < 200; cnt++)
      settle;
    `CHK("len", 1'h1, cnt > 0 && cnt < 200 && cnt + 1 >= fdoc_pkg::SOFT_RST_MIN_CYC)
    acc(0, fdoc_pkg::ADDR_TAPE_DRIVE_SELECT, 8'h00);
    `CHK("keep", 2'h3, rd_data[1:0])
    acc(1, 10'h3f0, 8'h00);
    acc(0, DOC, 8'h00);
    `CHK("doc", 8'h8f, rd_data)
    acc(0, 10'h3f4, 8'h00);
    `CHK("float", 8'hff, rd_oe_n)
    acc(1, DOC, 8'h14);
    settle;
    `CHK("shut", 6'h30, gate_view)
    @(posedge mclk);
    sys_mode <= fdoc_pkg::FDOC_SYS_ALTERNATE;
    core_req <= 1'h0;
    rst_n <= 1'h0;
    settle;
    `CHK("rst", 2'h0, {dma_req_oe_n, floppy_irq_oe_n})
    @(posedge mclk);
    rst_n <= 1'h1;
    acc(0, DOC, 8'h00);
    `CHK("alt", 10'h000, {rd_data, dma_req_oe_n, dma_req_out})
    @(posedge mclk);
    decode_mode <= fdoc_pkg::FDOC_DEC_SWAPPED;
    acc(1, DOC, 8'h1c);
    settle;
    `CHK("swap", 8'hdd, pins)
    @(posedge mclk);
    decode_mode <= fdoc_pkg::FDOC_DEC_EXTERNAL;
    acc(1, DOC, 8'h2d);
    settle;
    `CHK("ext", 8'hde, pins)
    wrap_up;
  end
endmodule
